//--- tcc_timer.sv
// 16-bit timer with four capture/compare/pwm channels, wishbone slave
//
// Operation
// - a 16-bit counter counts clock ticks or events, timebase for channels
// - four channels, each set to capture, compare or pwm mode
// - capture mode copies the counter into a buffer on the input event
// - compare mode output follows counter compared with channel threshold
// - pwm mode output shape follows successive written compare values
// - optional dead-time on complementary pwm exists on instance zero only
// - compare matches and overflows go out as events on the routing network
`timescale 1ns/1ps
module tcc_timer
   import tcc_pkg::*;
#(
   parameter int INST_ID = 0
)(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RST_B,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   input  wire logic        I_CNT_EVT,
   input  wire logic [3:0]  I_CAP_EVT,
   output logic      [31:0] O_WB_DAT,
   output logic             O_WB_ACK,
   output logic             O_IRQ,
   output logic      [3:0]  O_CH_OUT,
   output logic             O_DT_P,
   output logic             O_DT_N,
   output logic             O_EVT_OVF,
   output logic      [3:0]  O_EVT_CC
);

   // dead-time hardware is built only into the first instance
   localparam bit HAS_DT = (INST_ID == 0);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [1:0]       ctrl_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [4:0]       stat_ff;
   logic [4:0]       mask_ff;
   logic [DT_W-1:0]  dtime_ff;
   ch_mode_t         mode_ff [CH_N];
   logic [CNT_W-1:0] thr_ff  [CH_N];
   logic [CNT_W-1:0] cap     [CH_N];
   logic [CH_N-1:0]  ch_out;
   logic [CH_N-1:0]  ch_hit;

   logic             req;
   logic             wr;
   logic             is_ch;
   logic [1:0]       ch_idx;
   logic [31:0]      wmask;
   logic [31:0]      rd_data;
   logic             tick;
   logic             cnt_wr;
   logic             wrap;
   logic [4:0]       nxt_stat;

   dt_state_t        dt_st_ff;
   dt_state_t        nxt_dt_st;
   logic [DT_W-1:0]  dt_cnt_ff;
   logic [DT_W-1:0]  nxt_dt_cnt;
   logic             dt_src;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // one request per ack; ack drops the cycle after it is given
   assign req    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   assign wr     = req && I_WB_WE;
   assign is_ch  = (I_WB_ADR[7:5] == ADR_CH_HI) && (I_WB_ADR[1:0] == 2'h0);
   assign ch_idx = I_WB_ADR[4:3];
   assign wmask  = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                    {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      if (is_ch) begin
         if (I_WB_ADR[2]) begin
            rd_data[CNT_W-1:0] = (mode_ff[ch_idx] == MODE_CAP)
                               ? cap[ch_idx] : thr_ff[ch_idx];
         end else begin
            rd_data[1:0] = mode_ff[ch_idx];
         end
      end else begin
         case (I_WB_ADR)
            ADR_CTRL:  rd_data[1:0]       = ctrl_ff;
            ADR_CNT:   rd_data[CNT_W-1:0] = cnt_ff;
            ADR_STAT:  rd_data[4:0]       = stat_ff;
            ADR_MASK:  rd_data[4:0]       = mask_ff;
            ADR_DTIME: rd_data[DT_W-1:0]  = HAS_DT ? dtime_ff : 8'h00;
            default:   rd_data            = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
      end else begin
         O_WB_ACK <= req;
         if (req) begin
            O_WB_DAT <= rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl_ff  <= RST_CTRL;
         mask_ff  <= RST_MASK;
         dtime_ff <= RST_DTIME;
      end else if (wr && !is_ch) begin
         case (I_WB_ADR)
            ADR_CTRL: ctrl_ff <= 2'(merge({30'h0, ctrl_ff}, I_WB_DAT,
                                          wmask));
            ADR_MASK: mask_ff <= 5'(merge({27'h0, mask_ff}, I_WB_DAT,
                                          wmask));
            ADR_DTIME: begin
               if (HAS_DT) begin
                  dtime_ff <= DT_W'(merge({24'h0, dtime_ff}, I_WB_DAT,
                                          wmask));
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         for (int i = 0; i < CH_N; i++) begin
            mode_ff[i] <= MODE_OFF;
            thr_ff[i]  <= RST_VAL;
         end
      end else if (wr && is_ch) begin
         if (I_WB_ADR[2]) begin
            thr_ff[ch_idx] <= CNT_W'(merge({16'h0, thr_ff[ch_idx]},
                                           I_WB_DAT, wmask));
         end else if (I_WB_SEL[0]) begin
            mode_ff[ch_idx] <= ch_mode_t'(I_WB_DAT[1:0]);
         end
      end
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   assign tick   = ctrl_ff[CTRL_RUN] &&
                   (!ctrl_ff[CTRL_EVSEL] || I_CNT_EVT);
   assign cnt_wr = wr && !is_ch && (I_WB_ADR == ADR_CNT);
   assign wrap   = tick && !cnt_wr && (cnt_ff == CNT_MAX);

   // a software load beats a tick in the same cycle
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         cnt_ff <= CNT_ZERO;
      end else if (cnt_wr) begin
         cnt_ff <= CNT_W'(merge({16'h0, cnt_ff}, I_WB_DAT, wmask));
      end else if (tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   for (genvar g = 0; g < CH_N; g++) begin : g_ch
      tcc_channel u_ch (
         .i_clk     (I_CLK_SYS),
         .i_rst_b   (I_RST_B),
         .i_mode    (mode_ff[g]),
         .i_thr     (thr_ff[g]),
         .i_cnt     (cnt_ff),
         .i_tick    (tick),
         .i_wrap    (wrap),
         .i_cap_evt (I_CAP_EVT[g]),
         .o_cap     (cap[g]),
         .o_out     (ch_out[g]),
         .o_hit     (ch_hit[g])
      );
   end

   assign O_CH_OUT = ch_out;

   // ----------------------------------------------------------------
   // event network outputs
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_EVT_OVF <= 1'b0;
      end else begin
         O_EVT_OVF <= wrap;
      end
   end

   // channel hits are already registered pulses
   assign O_EVT_CC = ch_hit;

   // ----------------------------------------------------------------
   // status and interrupt
   // ----------------------------------------------------------------
   // a new event in the clearing cycle survives the clear
   always_comb begin
      nxt_stat = stat_ff;
      if (wr && !is_ch && (I_WB_ADR == ADR_STAT) && I_WB_SEL[0]) begin
         nxt_stat = stat_ff & ~I_WB_DAT[4:0];
      end
      nxt_stat = nxt_stat | {ch_hit, wrap};
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         stat_ff <= RST_STAT;
         O_IRQ   <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         O_IRQ   <= |(nxt_stat & mask_ff);
      end
   end

   // ----------------------------------------------------------------
   // dead-time on channel 0
   // ----------------------------------------------------------------
   // both legs stay low for dtime + 1 cycles around every edge of the pwm
   assign dt_src = HAS_DT && (mode_ff[0] == MODE_PWM) && ch_out[0];

   always_comb begin
      nxt_dt_st  = dt_st_ff;
      nxt_dt_cnt = dt_cnt_ff;
      case (dt_st_ff)
         DT_LO: begin
            if (dt_src) begin
               nxt_dt_st  = DT_RISE;
               nxt_dt_cnt = dtime_ff;
            end
         end
         DT_RISE: begin
            if (!dt_src) begin
               nxt_dt_st = DT_LO;
            end else if (dt_cnt_ff == 8'h00) begin
               nxt_dt_st = DT_HI;
            end else begin
               nxt_dt_cnt = dt_cnt_ff - 8'h01;
            end
         end
         DT_HI: begin
            if (!dt_src) begin
               nxt_dt_st  = DT_FALL;
               nxt_dt_cnt = dtime_ff;
            end
         end
         DT_FALL: begin
            if (dt_src) begin
               nxt_dt_st = DT_HI;
            end else if (dt_cnt_ff == 8'h00) begin
               nxt_dt_st = DT_LO;
            end else begin
               nxt_dt_cnt = dt_cnt_ff - 8'h01;
            end
         end
         default: nxt_dt_st = DT_LO;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         dt_st_ff  <= DT_LO;
         dt_cnt_ff <= 8'h00;
         O_DT_P    <= 1'b0;
         O_DT_N    <= 1'b0;
      end else begin
         dt_st_ff  <= nxt_dt_st;
         dt_cnt_ff <= nxt_dt_cnt;
         // complementary leg only driven while channel 0 is in pwm
         O_DT_P    <= HAS_DT && (nxt_dt_st == DT_HI);
         O_DT_N    <= HAS_DT && (mode_ff[0] == MODE_PWM) &&
                      (nxt_dt_st == DT_LO);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);

   property p_count_step;
      tick && !cnt_wr && (cnt_ff != CNT_MAX) |=>
         cnt_ff == $past(cnt_ff) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not advance on tick");

   property p_wrap_flag;
      wrap |=> (cnt_ff == CNT_ZERO) && stat_ff[STAT_OVF];
   endproperty
   a_wrap_flag: assert property (p_wrap_flag)
      else $error("wrap did not clear counter or set overflow");

   property p_ovf_event;
      wrap |=> O_EVT_OVF ##1 !O_EVT_OVF || $past(wrap);
   endproperty
   a_ovf_event: assert property (p_ovf_event)
      else $error("overflow event missing or stretched");

   property p_dt_excl;
      !(O_DT_P && O_DT_N) && (HAS_DT || (!O_DT_P && !O_DT_N));
   endproperty
   a_dt_excl: assert property (p_dt_excl)
      else $error("dead-time legs overlap or exist without support");

   sequence s_rise_start;
      (dt_st_ff == DT_LO) && dt_src && (dtime_ff != 8'h00);
   endsequence

   sequence s_gap;
      !O_DT_P && !O_DT_N;
   endsequence

   property p_dt_gap;
      s_rise_start |=> s_gap;
   endproperty
   a_dt_gap: assert property (p_dt_gap)
      else $error("no dead band after pwm rising edge");

endmodule : tcc_timer

//--- tcc_pkg.sv
// constants and types shared by the timer and its channels
package tcc_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int          CNT_W     = 16;
   localparam int          CH_N      = 4;
   localparam int          DT_W      = 8;
   localparam logic [15:0] CNT_MAX   = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL  = 8'h00;
   localparam logic [7:0]  ADR_CNT   = 8'h04;
   localparam logic [7:0]  ADR_STAT  = 8'h08;
   localparam logic [7:0]  ADR_MASK  = 8'h0C;
   localparam logic [7:0]  ADR_DTIME = 8'h10;
   // channel n: config at 0x20 + 8n, value at 0x24 + 8n
   localparam logic [2:0]  ADR_CH_HI = 3'h1;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          CTRL_RUN   = 0;
   localparam int          CTRL_EVSEL = 1;
   localparam int          STAT_OVF   = 0;
   localparam int          STAT_CH0   = 1;
   localparam int          STAT_W     = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  RST_CTRL  = 2'h0;
   localparam logic [4:0]  RST_STAT  = 5'h00;
   localparam logic [4:0]  RST_MASK  = 5'h00;
   localparam logic [7:0]  RST_DTIME = 8'h00;
   localparam logic [15:0] RST_VAL   = 16'h0000;

   // ----------------------------------------------------------------
   // modes and states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_CAP = 2'h1,
      MODE_CMP = 2'h2,
      MODE_PWM = 2'h3
   } ch_mode_t;

   typedef enum logic [1:0] {
      DT_LO   = 2'b00,
      DT_RISE = 2'b01,
      DT_HI   = 2'b11,
      DT_FALL = 2'b10
   } dt_state_t;

endpackage : tcc_pkg

//--- tcc_channel.sv
// one capture / compare / pwm channel of the timer
`timescale 1ns/1ps
module tcc_channel
   import tcc_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_rst_b,
   input  wire ch_mode_t         i_mode,
   input  wire logic [CNT_W-1:0] i_thr,
   input  wire logic [CNT_W-1:0] i_cnt,
   input  wire logic             i_tick,
   input  wire logic             i_wrap,
   input  wire logic             i_cap_evt,
   output logic [CNT_W-1:0]      o_cap,
   output logic                  o_out,
   output logic                  o_hit
);

   logic [CNT_W-1:0] buf_ff;
   logic             nxt_out;

   // ----------------------------------------------------------------
   // capture
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cap <= RST_VAL;
      end else if (i_mode == MODE_CAP && i_cap_evt) begin
         o_cap <= i_cnt;
      end
   end

   // ----------------------------------------------------------------
   // pwm threshold buffer
   // ----------------------------------------------------------------
   // new duty only at wrap, so a period never sees a torn threshold
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         buf_ff <= RST_VAL;
      end else if (i_mode != MODE_PWM || i_wrap) begin
         buf_ff <= i_thr;
      end
   end

   // ----------------------------------------------------------------
   // output and match event
   // ----------------------------------------------------------------
   always_comb begin
      case (i_mode)
         MODE_CMP: nxt_out = (i_cnt >= i_thr);
         MODE_PWM: nxt_out = (i_cnt < buf_ff);
         default:  nxt_out = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_out <= 1'b0;
         o_hit <= 1'b0;
      end else begin
         o_out <= nxt_out;
         case (i_mode)
            MODE_CAP: o_hit <= i_cap_evt;
            MODE_CMP: o_hit <= i_tick && (i_cnt == i_thr);
            MODE_PWM: o_hit <= i_tick && (i_cnt == buf_ff);
            default:  o_hit <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   property p_cap_copy;
      (i_mode == MODE_CAP) && i_cap_evt |=> o_cap == $past(i_cnt);
   endproperty
   a_cap_copy: assert property (p_cap_copy)
      else $error("capture did not store the counter");

   property p_cmp_out;
      i_mode == MODE_CMP |=> o_out == ($past(i_cnt) >= $past(i_thr));
   endproperty
   a_cmp_out: assert property (p_cmp_out)
      else $error("compare output disagrees with threshold");

   property p_pwm_load;
      (i_mode == MODE_PWM) && i_wrap |=> buf_ff == $past(i_thr) ##1
         (i_mode != MODE_PWM) || o_out == ($past(i_cnt) < buf_ff);
   endproperty
   a_pwm_load: assert property (p_pwm_load)
      else $error("pwm threshold not taken at wrap");

   property p_off_low;
      i_mode == MODE_OFF |=> !o_out && !o_hit;
   endproperty
   a_off_low: assert property (p_off_low)
      else $error("disabled channel is active");

endmodule : tcc_channel

//--- tcc_far_side.sv
// far-side model: event sources and event consumers around the timer
`timescale 1ns/1ps
module tcc_far_side (
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_evt_on,
   input  wire logic [3:0] i_cap_req,
   input  wire logic       i_evt_ovf,
   input  wire logic [3:0] i_evt_cc,
   output logic            o_cnt_evt,
   output logic      [3:0] o_cap_evt,
   output logic      [7:0] o_n_ovf,
   output logic      [7:0] o_n_cc
);
   // ----------------------------------------------------------------
   // sources: registered so edges never land on the sampling edge
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cnt_evt <= 1'h0;
         o_cap_evt <= 4'h0;
      end else begin
         o_cnt_evt <= i_evt_on;
         o_cap_evt <= i_cap_req;
      end
   end
   // ----------------------------------------------------------------
   // consumers: tally every trigger pulse that arrives
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_n_ovf <= 8'h00;
         o_n_cc  <= 8'h00;
      end else begin
         o_n_ovf <= o_n_ovf + {7'h00, i_evt_ovf};
         o_n_cc  <= o_n_cc + 8'($countones(i_evt_cc));
      end
   end
endmodule : tcc_far_side

//--- timer_capture_compare_pwm_bench.sv
// self-checking bench for the timer, a twin without dead time, far side
`timescale 1ns/1ps
module timer_capture_compare_pwm_bench;
   import tcc_pkg::*;
   logic        clk, rst_b, cyc, stb, we, ack, irq, dt_p, dt_n, dt_p1;
   logic        ovf, cnt_evt, evt_on;
   logic [7:0]  adr, n_ovf, n_cc;
   logic [3:0]  sel, ch_out, evt_cc, cap_evt, cap_req;
   logic [31:0] wdat, dat0, dat1, rdat, rdat1, a0;
   logic [15:0] v, x, y;
   int          n_mismatch, samples_checked, seed, c, d;

   tcc_timer #(.INST_ID(0)) tcc_timer_i (
      .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .I_CNT_EVT(cnt_evt), .I_CAP_EVT(cap_evt), .O_WB_DAT(dat0),
      .O_WB_ACK(ack), .O_IRQ(irq), .O_CH_OUT(ch_out), .O_DT_P(dt_p),
      .O_DT_N(dt_n), .O_EVT_OVF(ovf), .O_EVT_CC(evt_cc));
   // twin on the same bus: shows what an instance without dead time does
   tcc_timer #(.INST_ID(1)) tcc_timer_alt_i (
      .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
      .I_CNT_EVT(cnt_evt), .I_CAP_EVT(cap_evt), .O_WB_DAT(dat1),
      .O_WB_ACK(), .O_IRQ(), .O_CH_OUT(), .O_DT_P(dt_p1), .O_DT_N(),
      .O_EVT_OVF(), .O_EVT_CC());
   tcc_far_side tcc_far_side_i (
      .i_clk(clk), .i_rst_b(rst_b), .i_evt_on(evt_on), .i_cap_req(cap_req),
      .i_evt_ovf(ovf), .i_evt_cc(evt_cc), .o_cnt_evt(cnt_evt),
      .o_cap_evt(cap_evt), .o_n_ovf(n_ovf), .o_n_cc(n_cc));

   // ----------------------------------------------------------------
   // expectations and comparisons
   // ----------------------------------------------------------------
   function automatic logic exp_out(ch_mode_t m, logic [15:0] cn,
                                    logic [15:0] t);
      case (m)
         MODE_CMP: return cn >= t;
         MODE_PWM: return cn < t;
         default:  return 1'h0;
      endcase
   endfunction : exp_out

   function automatic logic [7:0] ch_adr(int n, logic hi);
      return 8'h20 + 8'(8 * n) + (hi ? 8'h04 : 8'h00);
   endfunction : ch_adr

   task automatic chk_word(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(input string nm, input logic e, g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // ----------------------------------------------------------------
   // bus cycles: hold the request until ack, release after that edge
   // ----------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] dw);
      int t;
      t = 0;
      @(posedge clk);
      cyc  <= 1'h1;
      stb  <= 1'h1;
      we   <= w;
      adr  <= a;
      wdat <= dw;
      sel  <= 4'hF;
      // ack is looked at on the rising edge, before that edge updates it
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'h1 && t < 50);
      if (t >= 50) n_mismatch++;
      rdat  = dat0;
      rdat1 = dat1;
      cyc <= 1'h0;
      stb <= 1'h0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      wb(1'h0, a, 32'h0);
      chk_word(nm, e, rdat);
   endtask : rd

   // counter parked at cn, then the channel output is looked at
   task automatic out_at(input int n, input ch_mode_t m,
                         input logic [15:0] cn, t);
      wb(1'h1, ADR_CNT, {16'h0000, cn});
      repeat (2) @(negedge clk);
      chk_bit("channel out", exp_out(m, cn, t), ch_out[n]);
   endtask : out_at

   // cycles from the channel edge to the matching dead-time edge
   task automatic span(input logic lvl, output int cc);
      int t;
      t = 0;
      do begin
         @(negedge clk);
         t++;
      end while (ch_out[0] !== lvl && t < 40);
      cc = 0;
      while ((lvl ? dt_p : dt_n) !== 1'h1 && cc < 40) begin
         @(negedge clk);
         cc++;
      end
   endtask : span

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      seed = 32'h96D2;
      {rst_b, cyc, stb, we, evt_on} = 5'h00;
      {adr, sel, cap_req, wdat} = 48'h0;
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      // ---------------- reset values, unmapped place ----------------
      rd(ADR_CTRL, 32'h0, "ctrl reset");
      rd(ADR_STAT, 32'h0, "status reset");
      rd(ADR_MASK, 32'h0, "mask reset");
      rd(ch_adr(3, 1'h0), 32'h0, "mode reset");
      wb(1'h1, 8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0, "unmapped");
      // ---------------- counting ticks and events ----------------
      wb(1'h1, ADR_CNT, 32'($random(seed) & 32'h7FFF));
      for (int k = 0; k < 3; k++) begin
         evt_on <= (k == 2);
         wb(1'h1, ADR_CTRL, (k == 0) ? 32'h1 : 32'h3);
         wb(1'h0, ADR_CNT, 32'h0);
         a0 = rdat;
         wb(1'h0, ADR_CNT, 32'h0);
         chk_word("count step", (k == 1) ? 32'h0 : 32'h3, rdat - a0);
      end
      evt_on <= 1'h0;
      // ---------------- wrap, overflow flag, interrupt ----------------
      wb(1'h1, ADR_CTRL, 32'h0);
      wb(1'h1, ADR_MASK, 32'h1);
      wb(1'h1, ADR_CNT, 32'hFFFE);
      wb(1'h1, ADR_CTRL, 32'h1);
      wb(1'h0, ADR_CNT, 32'h0);
      chk_bit("count wrapped", 1'h1, rdat < 32'h20);
      rd(ADR_STAT, 32'h1, "overflow flag");
      chk_bit("irq raised", 1'h1, irq);
      chk_word("overflow events", 32'h1, {24'h0, n_ovf});
      wb(1'h1, ADR_STAT, 32'h1);
      rd(ADR_STAT, 32'h0, "flag cleared");
      chk_bit("irq cleared", 1'h0, irq);
      wb(1'h1, ADR_CTRL, 32'h0);
      wb(1'h1, ADR_MASK, 32'h0);
      // ---------------- capture on every channel ----------------
      for (int n = 0; n < CH_N; n++) begin
         v = 16'($random(seed));
         wb(1'h1, ch_adr(n, 1'h0), {30'h0, MODE_CAP});
         wb(1'h1, ADR_CNT, {16'h0000, v});
         cap_req <= 4'(1 << n);
         @(posedge clk);
         cap_req <= 4'h0;
         rd(ch_adr(n, 1'h1), {16'h0000, v}, "captured");
         wb(1'h1, ch_adr(n, 1'h0), {30'h0, MODE_OFF});
      end
      chk_word("capture events", 32'h4, {24'h0, n_cc});
      rd(ADR_STAT, 32'h1E, "capture flags");
      chk_bit("irq masked", 1'h0, irq);
      wb(1'h1, ADR_MASK, 32'h1E);
      repeat (2) @(negedge clk);
      chk_bit("irq unmasked", 1'h1, irq);
      wb(1'h1, ADR_STAT, 32'h1E);
      repeat (2) @(negedge clk);
      chk_bit("irq after clear", 1'h0, irq);
      // ---------------- compare below, at and above threshold ----------
      for (int n = 0; n < CH_N; n++) begin
         x = 16'h0100 + 16'($random(seed) & 32'h7FFF);
         wb(1'h1, ch_adr(n, 1'h1), {16'h0000, x});
         wb(1'h1, ch_adr(n, 1'h0), {30'h0, MODE_CMP});
         for (int k = -1; k < 2; k++) out_at(n, MODE_CMP, x + 16'(k), x);
         wb(1'h1, ch_adr(n, 1'h0), {30'h0, MODE_OFF});
         out_at(n, MODE_OFF, x, x);
      end
      // ---------------- a running count passes one threshold once ------
      wb(1'h1, ch_adr(1, 1'h1), 32'h1);
      wb(1'h1, ch_adr(1, 1'h0), {30'h0, MODE_CMP});
      wb(1'h1, ADR_CNT, 32'h0);
      wb(1'h1, ADR_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      wb(1'h1, ADR_CTRL, 32'h0);
      chk_word("match events", 32'h5, {24'h0, n_cc});
      wb(1'h1, ch_adr(1, 1'h0), {30'h0, MODE_OFF});
      // ---------------- pwm buffer reloads only at wrap ----------------
      x = 16'h0100 + 16'($random(seed) & 32'h7FFF);
      y = x - 16'h0008;
      wb(1'h1, ch_adr(2, 1'h1), {16'h0000, x});
      wb(1'h1, ch_adr(2, 1'h0), {30'h0, MODE_PWM});
      out_at(2, MODE_PWM, x - 16'h1, x);
      out_at(2, MODE_PWM, x, x);
      wb(1'h1, ch_adr(2, 1'h1), {16'h0000, y});
      out_at(2, MODE_PWM, x - 16'h1, x);
      wb(1'h1, ADR_CNT, 32'hFFFE);
      wb(1'h1, ADR_CTRL, 32'h1);
      wb(1'h1, ADR_CTRL, 32'h0);
      out_at(2, MODE_PWM, x - 16'h1, y);
      out_at(2, MODE_PWM, y - 16'h1, y);
      wb(1'h1, ch_adr(2, 1'h0), {30'h0, MODE_OFF});
      // ---------------- dead time on channel zero ----------------
      d = 1 + ($random(seed) & 3);
      wb(1'h1, ADR_DTIME, 32'(d));
      rd(ADR_DTIME, 32'(d), "dead time");
      chk_word("twin dead time", 32'h0, rdat1);
      wb(1'h1, ch_adr(0, 1'h1), 32'h0100);
      wb(1'h1, ch_adr(0, 1'h0), {30'h0, MODE_PWM});
      wb(1'h1, ADR_CNT, 32'h0200);
      repeat (12) @(negedge clk);
      chk_bit("low side idle", 1'h1, dt_n);
      wb(1'h1, ADR_CNT, 32'h0050);
      span(1'h1, c);
      chk_word("rise delay", 32'(d + 2), 32'(c));
      chk_bit("low side off", 1'h0, dt_n);
      chk_bit("twin high side", 1'h0, dt_p1);
      wb(1'h1, ADR_CNT, 32'h0200);
      span(1'h0, c);
      chk_word("fall delay", 32'(d + 2), 32'(c));
      chk_bit("high side off", 1'h0, dt_p);
      close_out();
   end
endmodule : timer_capture_compare_pwm_bench
